/* core/sbl_loader.sv */
`timescale 1ns/1ps
module sbl_loader (
    input  wire logic                      clock_i,
    input  wire logic                      sys_rst_i,
    input  wire logic                      rx_i,
    output logic                           tx_o,
    input  wire logic                      security_en_i,
    output logic                           mem_rd_o,
    output logic [sbl_pkg::MEM_AW-1:0]     mem_addr_o,
    input  wire logic [7:0]                mem_data_i,
    output logic                           ram_we_o,
    output logic [sbl_pkg::MEM_AW-1:0]     ram_addr_o,
    output logic [7:0]                     ram_data_o,
    output logic                           jump_o,
    output logic [sbl_pkg::MEM_AW-1:0]     jump_addr_o,
    output logic                           idle_o
);
    import sbl_pkg::*;

    sbl_uart_if u ();

    sbl_state_type st_q;
    sbl_state_type ret_q;
    sbl_field_type fld_q;
    logic [7:0]    txb_q [3];
    logic [1:0]    tx_n_q;
    logic [1:0]    tx_i_q;
    logic [47:0]   addr_q;
    logic [2:0]    acnt_q;
    logic          dv_q;
    logic          blank_q;
    logic [15:0]   sum_q;
    logic [7:0]    pwleft_q;
    logic [7:0]    pwb_q;
    logic [7:0]    len_q;
    logic [7:0]    rsum_q;
    logic [7:0]    rtype_q;
    logic          first_q;

    function automatic logic in_flash(input logic [23:0] a);
        in_flash = (a >= FLASH_LO) && (a <= FLASH_HI);
    endfunction

    // Byte decoding shared by the states below
    wire [7:0]  rxd      = u.rx_data;
    wire        rx_ok    = u.rx_valid & ~u.rx_ferr;
    wire        m2_ok    = (rxd == MATCH2_A) || (rxd == MATCH2_B);
    wire        cmd_unsp = (rxd == CMD_OTHER_A) || (rxd == CMD_OTHER_B);
    wire [23:0] cnt_addr = addr_q[47:24];
    wire [23:0] cmp_addr = addr_q[23:0];
    wire        cnt_ok   = in_flash(cnt_addr);
    wire        cmp_ok   = in_flash(cmp_addr);
    wire        mem_ff   = mem_data_i == BLANK_BYTE;
    wire [7:0]  rsum_nx  = rsum_q + rxd;
    wire [15:0] sum_rx   = sum_q + {8'h00, rxd};
    wire [15:0] sum_mem  = sum_q + {8'h00, mem_data_i};
    wire        tx_free  = ~u.tx_busy & ~u.tx_valid;
    wire [15:0] ptr_inc  = mem_addr_o + 16'h0001;

    sbl_uart i_uart (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .rx_i      (rx_i),
        .tx_o      (tx_o),
        .u         (u.uart)
    );

    // Read data is valid the cycle after the strobe
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            dv_q   <= 1'b0;
            idle_o <= 1'b0;
        end else begin
            dv_q   <= mem_rd_o;
            // Flagged only once the last queued byte has left the line
            idle_o <= (st_q == ST_DEAD) && tx_free;
        end
    end

    // Session sequencer; silent idle needs a reset to leave
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            st_q        <= ST_BAUD;
            ret_q       <= ST_DEAD;
            fld_q       <= F_MARK;
            txb_q       <= '{8'h00, 8'h00, 8'h00};
            tx_n_q      <= '0;
            tx_i_q      <= '0;
            addr_q      <= '0;
            acnt_q      <= '0;
            blank_q     <= 1'b1;
            sum_q       <= '0;
            pwleft_q    <= '0;
            pwb_q       <= '0;
            len_q       <= '0;
            rsum_q      <= '0;
            rtype_q     <= '0;
            first_q     <= 1'b1;
            mem_rd_o    <= 1'b0;
            mem_addr_o  <= '0;
            ram_we_o    <= 1'b0;
            ram_addr_o  <= '0;
            ram_data_o  <= '0;
            jump_o      <= 1'b0;
            jump_addr_o <= '0;
            u.tx_valid  <= 1'b0;
            u.tx_data   <= '0;
        end else begin
            mem_rd_o   <= 1'b0;
            ram_we_o   <= 1'b0;
            jump_o     <= 1'b0;
            u.tx_valid <= 1'b0;
            tx_i_q     <= (st_q == ST_TX) ? tx_i_q : 2'h0;
            unique case (st_q)
                ST_BAUD: if (u.ab_done && u.ab_ok) begin
                    txb_q[0] <= u.ab_code;
                    tx_n_q   <= 2'h1;
                    ret_q    <= ST_MATCH2;
                    st_q     <= ST_TX;
                end
                ST_MATCH2: if (u.rx_valid) begin
                    if (rx_ok && m2_ok) begin
                        txb_q[0] <= rxd;
                        tx_n_q   <= 2'h1;
                        ret_q    <= ST_CMD;
                        st_q     <= ST_TX;
                    end else begin
                        st_q <= ST_DEAD;
                    end
                end
                ST_CMD: if (u.rx_valid) begin
                    tx_n_q <= ERR_COUNT;
                    ret_q  <= ST_DEAD;
                    if (u.rx_ferr) begin
                        txb_q <= '{ERR_FRAME, ERR_FRAME, ERR_FRAME};
                        st_q  <= ST_TX;
                    end else if (security_en_i &&
                                 (rxd == CMD_RAM || rxd == CMD_SUM)) begin
                        st_q <= ST_DEAD;
                    end else if (rxd == CMD_RAM) begin
                        txb_q[0] <= CMD_RAM;
                        tx_n_q   <= 2'h1;
                        ret_q    <= ST_ADDR;
                        acnt_q   <= '0;
                        st_q     <= ST_TX;
                    end else if (rxd == CMD_SUM) begin
                        mem_addr_o <= FLASH_LO[15:0];
                        sum_q      <= '0;
                        blank_q    <= 1'b1;
                        st_q       <= ST_SUM;
                    end else if (cmd_unsp) begin
                        txb_q <= '{ERR_UNSUPP, ERR_UNSUPP, ERR_UNSUPP};
                        st_q  <= ST_TX;
                    end else begin
                        txb_q <= '{ERR_CMD, ERR_CMD, ERR_CMD};
                        st_q  <= ST_TX;
                    end
                end
                // Six address bytes, high first, no reply
                ST_ADDR: if (u.rx_valid) begin
                    if (u.rx_ferr) begin
                        st_q <= ST_DEAD;
                    end else begin
                        addr_q <= {addr_q[39:0], rxd};
                        acnt_q <= acnt_q + 3'h1;
                        if (acnt_q == ADDR_LAST) begin
                            mem_addr_o <= PW_AREA_LO;
                            blank_q    <= 1'b1;
                            st_q       <= ST_BLANK;
                        end
                    end
                end
                ST_BLANK: if (dv_q) begin
                    blank_q <= blank_q & mem_ff;
                    if (mem_addr_o == PW_AREA_HI) begin
                        st_q <= ST_PWCHK;
                    end else begin
                        mem_addr_o <= ptr_inc;
                    end
                end else if (!mem_rd_o) begin
                    mem_rd_o <= 1'b1;
                end
                ST_PWCHK: begin
                    fld_q   <= F_MARK;
                    first_q <= 1'b1;
                    sum_q   <= '0;
                    if (blank_q) begin
                        st_q <= ST_HEX;
                    end else if (!(cnt_ok && cmp_ok)) begin
                        st_q <= ST_DEAD;
                    end else begin
                        mem_addr_o <= cnt_addr[15:0];
                        mem_rd_o   <= 1'b1;
                        st_q       <= ST_PWCNT;
                    end
                end
                ST_PWCNT: if (dv_q) begin
                    pwleft_q   <= mem_data_i;
                    mem_addr_o <= cmp_addr[15:0];
                    st_q       <= (mem_data_i == 8'h00) ? ST_DEAD : ST_PWSTR;
                end
                // One flash read per received password byte
                ST_PWSTR: if (u.rx_valid) begin
                    pwb_q    <= rxd;
                    mem_rd_o <= ~u.rx_ferr;
                    st_q     <= u.rx_ferr ? ST_DEAD : ST_PWSTR;
                end else if (dv_q) begin
                    mem_addr_o <= ptr_inc;
                    pwleft_q   <= pwleft_q - 8'h01;
                    if (mem_data_i != pwb_q) begin
                        st_q <= ST_DEAD;
                    end else if (pwleft_q == 8'h01) begin
                        st_q <= ST_HEX;
                    end
                end
                // Records: mark, length, address, type, data, checksum
                ST_HEX: if (u.rx_valid && u.rx_ferr) begin
                    st_q <= ST_DEAD;
                end else if (u.rx_valid) begin
                    rsum_q <= rsum_nx;
                    unique case (fld_q)
                        F_MARK: begin
                            rsum_q <= '0;
                            fld_q  <= F_LEN;
                            st_q   <= (rxd == HEX_MARK) ? ST_HEX : ST_DEAD;
                        end
                        F_LEN: begin
                            len_q <= rxd;
                            fld_q <= F_AHI;
                        end
                        F_AHI: begin
                            ram_addr_o[15:8] <= rxd;
                            fld_q            <= F_ALO;
                        end
                        F_ALO: begin
                            ram_addr_o[7:0] <= rxd;
                            fld_q           <= F_TYPE;
                        end
                        F_TYPE: begin
                            rtype_q <= rxd;
                            fld_q   <= (len_q == 8'h00) ? F_CKS : F_DATA;
                            if (rxd != REC_DATA && rxd != REC_END) begin
                                st_q <= ST_DEAD;
                            end
                        end
                        F_DATA: begin
                            ram_we_o   <= 1'b1;
                            ram_data_o <= rxd;
                            sum_q      <= sum_rx;
                            len_q      <= len_q - 8'h01;
                            first_q    <= 1'b0;
                            if (first_q) begin
                                jump_addr_o <= ram_addr_o;
                            end
                            if (len_q == 8'h01) begin
                                fld_q <= F_CKS;
                            end
                        end
                        F_CKS: begin
                            fld_q <= F_MARK;
                            if (rsum_nx != 8'h00) begin
                                st_q <= ST_DEAD;
                            end else if (rtype_q == REC_END) begin
                                txb_q[0] <= sum_q[15:8];
                                txb_q[1] <= sum_q[7:0];
                                tx_n_q   <= 2'h2;
                                ret_q    <= ST_JUMP;
                                st_q     <= ST_TX;
                            end
                        end
                        default: st_q <= ST_DEAD;
                    endcase
                end else if (ram_we_o) begin
                    ram_addr_o <= ram_addr_o + 16'h0001;
                end
                ST_SUM: if (dv_q) begin
                    sum_q   <= sum_mem;
                    blank_q <= blank_q & mem_ff;
                    if (mem_addr_o == FLASH_HI[15:0]) begin
                        st_q <= ST_SUMOUT;
                    end else begin
                        mem_addr_o <= ptr_inc;
                    end
                end else if (!mem_rd_o) begin
                    mem_rd_o <= 1'b1;
                end
                ST_SUMOUT: begin
                    txb_q[0] <= blank_q ? SUM_BLANK : SUM_USED;
                    txb_q[1] <= sum_q[15:8];
                    txb_q[2] <= sum_q[7:0];
                    tx_n_q   <= 2'h3;
                    ret_q    <= ST_CMD;
                    st_q     <= ST_TX;
                end
                // Hands bytes to the transmitter one at a time
                ST_TX: if (tx_free) begin
                    u.tx_valid <= 1'b1;
                    u.tx_data  <= txb_q[tx_i_q];
                    tx_i_q     <= tx_i_q + 2'h1;
                    if (tx_i_q == tx_n_q - 2'h1) begin
                        st_q <= ret_q;
                    end
                end
                // Branch only once the last checksum byte has left
                ST_JUMP: if (tx_free) begin
                    jump_o <= 1'b1;
                    st_q   <= ST_DEAD;
                end
                ST_DEAD: st_q <= ST_DEAD;
                default: st_q <= ST_DEAD;
            endcase
        end
    end
endmodule

/* core/sbl_pkg.sv */
// Operation
// - First byte 0x86 or 0x30 sets baud; echoed on success, silent on failure.
// - Second byte 0x79 or 0xCF is echoed; anything else gets no answer.
// - After detection every byte both ways uses the adjusted bit period.
// - Accepted loader command 0x60 is echoed before further bytes are taken.
// - Rejected command sends one error code three times, then idles.
// - Skip password check when 0xFFE0 to 0xFFFF all read 0xFF.
// - Bad password address or password means silent idle until reset.
// - Security enabled makes the device idle instead of running command.
// - Framing error during password addresses or string means silent idle.
// - Good load returns checksum high then low; error returns nothing.
// - After load, branch to the address of the first data byte.
// - Command 0x90 selects sum output; rejection gives triple error code.
// - Sum answer starts with 0xAA if all bytes are 0xFF, else 0x55.
// - Sum status is followed by checksum high then low byte.
// - After the sum answer, wait for next command at the same rate.
package sbl_pkg;
    localparam int         MEM_AW      = 16;
    localparam int         BAUD_W      = 16;
    localparam logic [7:0] MATCH1_A    = 8'h86;
    localparam logic [7:0] MATCH1_B    = 8'h30;
    localparam logic [7:0] MATCH2_A    = 8'h79;
    localparam logic [7:0] MATCH2_B    = 8'hCF;
    localparam logic [7:0] CMD_RAM     = 8'h60;
    localparam logic [7:0] CMD_SUM     = 8'h90;
    localparam logic [7:0] CMD_OTHER_A = 8'h40;
    localparam logic [7:0] CMD_OTHER_B = 8'hC0;
    localparam logic [7:0] ERR_FRAME   = 8'hA1;
    localparam logic [7:0] ERR_UNSUPP  = 8'hA3;
    localparam logic [7:0] ERR_CMD     = 8'h63;
    localparam logic [7:0] SUM_BLANK   = 8'hAA;
    localparam logic [7:0] SUM_USED    = 8'h55;
    localparam logic [7:0] BLANK_BYTE  = 8'hFF;
    localparam logic [7:0] HEX_MARK    = 8'h3A;
    localparam logic [7:0] REC_DATA    = 8'h00;
    localparam logic [7:0] REC_END     = 8'h01;
    localparam logic [15:0] PW_AREA_LO = 16'hFFE0;
    localparam logic [15:0] PW_AREA_HI = 16'hFFFF;
    localparam logic [23:0] FLASH_LO   = 24'h00C000;
    localparam logic [23:0] FLASH_HI   = 24'h00FFFF;
    localparam logic [2:0]  ADDR_LAST  = 3'h5;
    localparam logic [1:0]  ERR_COUNT  = 2'h3;
    localparam logic [BAUD_W-1:0] AB_MIN_HIGH = 16'h0008;
    localparam logic [BAUD_W-1:0] AB_SAT      = 16'hFFFF;
    localparam logic [3:0]  RX_STOP_IDX = 4'h9;
    localparam logic [3:0]  TX_LAST_IDX = 4'h9;

    typedef enum logic [3:0] {
        ST_BAUD   = 4'h0,
        ST_MATCH2 = 4'h1,
        ST_CMD    = 4'h2,
        ST_ADDR   = 4'h3,
        ST_BLANK  = 4'h4,
        ST_PWCHK  = 4'h5,
        ST_PWCNT  = 4'h6,
        ST_PWSTR  = 4'h7,
        ST_HEX    = 4'h8,
        ST_SUM    = 4'h9,
        ST_SUMOUT = 4'hA,
        ST_TX     = 4'hB,
        ST_JUMP   = 4'hC,
        ST_DEAD   = 4'hD
    } sbl_state_type;

    typedef enum logic [2:0] {
        RX_AB_WAIT = 3'h0,
        RX_AB_LOW  = 3'h1,
        RX_AB_HIGH = 3'h2,
        RX_AB_TAIL = 3'h3,
        RX_IDLE    = 3'h4,
        RX_DATA    = 3'h5
    } sbl_rx_state_type;

    typedef enum logic [2:0] {
        F_MARK = 3'h0,
        F_LEN  = 3'h1,
        F_AHI  = 3'h2,
        F_ALO  = 3'h3,
        F_TYPE = 3'h4,
        F_DATA = 3'h5,
        F_CKS  = 3'h6
    } sbl_field_type;
endpackage

/* core/sbl_uart.sv */
`timescale 1ns/1ps
module sbl_uart (
    input  wire logic  clock_i,
    input  wire logic  sys_rst_i,
    input  wire logic  rx_i,
    output logic       tx_o,
    sbl_uart_if.uart   u
);
    import sbl_pkg::*;

    sbl_rx_state_type  rst_q;
    logic              prev_q;
    logic [BAUD_W-1:0] len_q;
    logic [BAUD_W-1:0] low_q;
    logic [BAUD_W-1:0] high_q;
    logic [BAUD_W-1:0] bit_q;
    logic [BAUD_W-1:0] rcnt_q;
    logic [3:0]        ridx_q;
    logic [7:0]        rsh_q;
    logic [BAUD_W-1:0] tcnt_q;
    logic [3:0]        tidx_q;
    logic [9:0]        tsh_q;

    // Both patterns have a two-bit high run after the first low run
    wire               fall    = prev_q & ~rx_i;
    wire [BAUD_W:0]    high_15 = {1'b0, high_q} + {2'b00, high_q[BAUD_W-1:1]};
    wire [BAUD_W:0]    high_2  = {high_q, 1'b0};
    wire               is_86   = {1'b0, low_q} <= high_15;
    wire               is_30   = {1'b0, low_q} > high_2;
    wire               rate_ok = high_q >= AB_MIN_HIGH;
    wire               ab_good = rate_ok & (is_86 | is_30);
    wire [BAUD_W-1:0]  len_inc = (len_q == AB_SAT) ? len_q : len_q + 16'h0001;
    wire               rtick   = rcnt_q == '0;
    wire               ttick   = tcnt_q == '0;

    // Receiver, with baud detection on the first frame
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rst_q      <= RX_AB_WAIT;
            prev_q     <= 1'b1;
            len_q      <= '0;
            low_q      <= '0;
            high_q     <= '0;
            bit_q      <= '0;
            rcnt_q     <= '0;
            ridx_q     <= '0;
            rsh_q      <= '0;
            u.rx_valid <= 1'b0;
            u.rx_ferr  <= 1'b0;
            u.rx_data  <= '0;
            u.ab_done  <= 1'b0;
            u.ab_ok    <= 1'b0;
            u.ab_code  <= '0;
        end else begin
            prev_q     <= rx_i;
            u.rx_valid <= 1'b0;
            u.ab_done  <= 1'b0;
            unique case (rst_q)
                RX_AB_WAIT: if (fall) begin
                    len_q <= 16'h0001; // This edge already saw the low level
                    rst_q <= RX_AB_LOW;
                end
                RX_AB_LOW: if (rx_i) begin
                    low_q <= len_q;
                    len_q <= 16'h0001;
                    rst_q <= RX_AB_HIGH;
                end else begin
                    len_q <= len_inc;
                end
                RX_AB_HIGH: if (!rx_i) begin
                    high_q <= len_q;
                    rst_q  <= RX_AB_TAIL;
                end else begin
                    len_q <= len_inc;
                end
                // Waits out the tail so the stop bit is not seen as data
                RX_AB_TAIL: if (rx_i) begin
                    bit_q     <= {1'b0, high_q[BAUD_W-1:1]};
                    u.ab_done <= 1'b1;
                    u.ab_ok   <= ab_good;
                    u.ab_code <= is_86 ? MATCH1_A : MATCH1_B;
                    rst_q     <= ab_good ? RX_IDLE : RX_AB_WAIT;
                end
                RX_IDLE: if (fall) begin
                    rcnt_q <= {1'b0, bit_q[BAUD_W-1:1]};
                    ridx_q <= '0;
                    rst_q  <= RX_DATA;
                end
                RX_DATA: if (rtick) begin
                    rcnt_q <= bit_q - 16'h0001;
                    ridx_q <= ridx_q + 4'h1;
                    if (ridx_q == '0 && rx_i) begin
                        rst_q <= RX_IDLE; // Glitch, not a start bit
                    end else if (ridx_q == RX_STOP_IDX) begin
                        u.rx_valid <= 1'b1;
                        u.rx_ferr  <= ~rx_i;
                        u.rx_data  <= rsh_q;
                        rst_q      <= RX_IDLE;
                    end else if (ridx_q != '0) begin
                        rsh_q <= {rx_i, rsh_q[7:1]};
                    end
                end else begin
                    rcnt_q <= rcnt_q - 16'h0001;
                end
                default: rst_q <= RX_AB_WAIT;
            endcase
        end
    end

    // Transmitter, LSB first, one stop bit
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            tx_o      <= 1'b1;
            tcnt_q    <= '0;
            tidx_q    <= '0;
            tsh_q     <= '1;
            u.tx_busy <= 1'b0;
        end else if (!u.tx_busy) begin
            if (u.tx_valid) begin
                tsh_q     <= {1'b1, u.tx_data, 1'b0};
                tcnt_q    <= '0;
                tidx_q    <= '0;
                u.tx_busy <= 1'b1;
            end
        end else if (ttick) begin
            tcnt_q <= bit_q - 16'h0001;
            if (tidx_q == TX_LAST_IDX + 4'h1) begin
                u.tx_busy <= 1'b0;
            end else begin
                tx_o   <= tsh_q[0];
                tsh_q  <= {1'b1, tsh_q[9:1]};
                tidx_q <= tidx_q + 4'h1;
            end
        end else begin
            tcnt_q <= tcnt_q - 16'h0001;
        end
    end
endmodule

/* core/sbl_uart_if.sv */
`timescale 1ns/1ps
interface sbl_uart_if;
    logic       rx_valid;
    logic       rx_ferr;
    logic [7:0] rx_data;
    logic       ab_done;
    logic       ab_ok;
    logic [7:0] ab_code;
    logic       tx_valid;
    logic [7:0] tx_data;
    logic       tx_busy;

    modport uart (output rx_valid, rx_ferr, rx_data, ab_done, ab_ok,
                  output ab_code, tx_busy, input tx_valid, tx_data);
    modport ctrl (input rx_valid, rx_ferr, rx_data, ab_done, ab_ok,
                  input ab_code, tx_busy, output tx_valid, tx_data);
endinterface

/* verif/sbl_flash_model.sv */
`timescale 1ns/1ps
// Flash part: data follows the strobe by one cycle
module sbl_flash_model (
    input  wire logic                       clock_i,
    input  wire logic                       used_i,
    input  wire logic                       mem_rd_i,
    input  wire logic [sbl_pkg::MEM_AW-1:0] mem_addr_i,
    output logic      [7:0]                 mem_data_o
);
    import sbl_pkg::*;
    // Bus toggles between reads so stale data never passes
    // Used part returns the address low byte, blank part 0xFF
    always @(posedge clock_i) begin
        mem_data_o <= !mem_rd_i ? ~mem_data_o :
            (used_i ? mem_addr_i[7:0] : BLANK_BYTE);
    end
endmodule

/* verif/sbl_loader_sva.sv */
`timescale 1ns/1ps
module sbl_loader_sva (
    input wire logic                       clock_i,
    input wire logic                       sys_rst_i,
    input wire logic                       tx_o,
    input wire logic                       mem_rd_o,
    input wire logic [sbl_pkg::MEM_AW-1:0] mem_addr_o,
    input wire logic                       ram_we_o,
    input wire logic                       jump_o,
    input wire logic                       idle_o
);
    import sbl_pkg::*;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    // Strobes are single pulses; flash address holds past the strobe
    property p_we; ram_we_o |=> !ram_we_o; endproperty
    property p_rd; mem_rd_o |=> !mem_rd_o && $stable(mem_addr_o); endproperty
    property p_rng; mem_rd_o |-> mem_addr_o >= FLASH_LO[15:0]; endproperty
    property p_quiet; ram_we_o |-> tx_o; endproperty
    property p_jump; jump_o |-> tx_o && !ram_we_o; endproperty
    // Dead state is silent and only reset leaves it
    property p_dead; idle_o |=> idle_o; endproperty
    property p_mute; idle_o |-> tx_o; endproperty
    property p_still; idle_o |-> !mem_rd_o && !ram_we_o; endproperty
    a_we: assert property (p_we) else $error("write pulse long");
    a_rd: assert property (p_rd) else $error("read pulse bad");
    a_rng: assert property (p_rng) else $error("read range");
    a_quiet: assert property (p_quiet) else $error("tx in load");
    a_jump: assert property (p_jump) else $error("jump early");
    a_dead: assert property (p_dead) else $error("left idle");
    a_mute: assert property (p_mute) else $error("tx in idle");
    a_still: assert property (p_still) else $error("idle busy");
    c_jump: cover property (jump_o);
    c_we: cover property (ram_we_o);
    c_idle: cover property ($rose(idle_o));
endmodule
bind sbl_loader sbl_loader_sva u_sva (.*);

/* verif/sbl_loader_test.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
$display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module sbl_loader_test;
    import sbl_pkg::*;
    logic              clock_i = 0, sys_rst_i = 1, rx_i = 1;
    logic              security_en_i = 0, used = 0, stop_lvl = 1;
    logic              tx_o, mem_rd_o, ram_we_o, jump_o, idle_o;
    logic [MEM_AW-1:0] mem_addr_o, ram_addr_o, jump_addr_o, wa = '0, ja = '0;
    logic [7:0]        mem_data_i, ram_data_o, wd = '0;
    int                fails = 0, check_count = 0, cyc = 0;
    sbl_loader uut (.*);
    sbl_flash_model u_flash (.clock_i(clock_i), .used_i(used),
        .mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o),
        .mem_data_o(mem_data_i));
    initial forever #2.5 clock_i = ~clock_i;
    // Capture writes and jump; ceiling sits well above the sum scan
    always @(posedge clock_i) begin
        if (ram_we_o === 1'b1) {wa, wd} <= {ram_addr_o, ram_data_o};
        if (jump_o === 1'b1) ja <= jump_addr_o;
        cyc++;
        if (cyc == 99000) begin
            fails++;
            wrap_up;
        end
    end
    // 8N1 frames at 16 cycles a bit, LSB first; low stop fakes a bad frame
    task send(input logic [7:0] b);
        for (int i = 0; i < 10; i++) begin
            rx_i = i == 0 ? 1'b0 : (i == 9 ? stop_lvl : b[i-1]);
            repeat (16) @(negedge clock_i);
        end
    endtask
    // Bit 8 holds the stop bit; all zero means nothing was sent
    task recv(input logic [8:0] e, input int lim);
        logic [8:0] g;
        int n;
        g = 9'h000;
        n = 0;
        while (tx_o === 1'b1 && n < lim) begin
            @(negedge clock_i);
            n++;
        end
        if (n < lim) begin
            repeat (8) @(negedge clock_i);
            for (int i = 0; i < 9; i++) begin
                repeat (16) @(negedge clock_i);
                g[i] = tx_o;
            end
        end
        `CHK(g, e)
    endtask
    task xfer(input logic [7:0] b, input logic [8:0] e);
        fork
            send(b);
            recv(e, 400);
        join
    endtask
    task rst;
        sys_rst_i = 1;
        repeat (5) @(negedge clock_i);
        sys_rst_i = 0;
    endtask
    task sync(input logic [7:0] a, input logic [7:0] b);
        xfer(a, {1'b1, a});
        xfer(b, {1'b1, b});
    endtask
    task t_load;
        logic [7:0] img [19];
        logic [23:0] s;
        img = '{8'h00, 8'hC0, 8'h00, 8'h00, 8'hC0, 8'h10, HEX_MARK, 8'h01,
            8'h12, 8'h34, REC_DATA, 8'h5A, 8'h5F, HEX_MARK, 8'h00, 8'h00,
            8'h00, REC_END, 8'hFF};
        s = (FLASH_HI - FLASH_LO + 24'h1) * 24'hFF;
        rst;
        sync(MATCH1_A, MATCH2_B);
        send(CMD_SUM);
        recv({1'b1, SUM_BLANK}, 80000);
        recv({1'b1, s[15:8]}, 400);
        recv({1'b1, s[7:0]}, 400);
        xfer(CMD_RAM, {1'b1, CMD_RAM});
        // Addresses, one data record, then the end record
        foreach (img[i]) send(img[i]);
        recv(9'h100, 400);
        recv(9'h15A, 400);
        repeat (40) @(negedge clock_i);
        `CHK({wa, wd}, 24'h12345A)
        `CHK(ja, 16'h1234)
    endtask
    task t_err;
        logic [8:0] e;
        for (int k = 0; k < 3; k++) begin
            e = {1'b1, k == 2 ? ERR_FRAME : k ? ERR_UNSUPP : ERR_CMD};
            rst;
            sync(MATCH1_B, MATCH2_A);
            stop_lvl = k != 2;
            xfer(k ? CMD_OTHER_A : 8'h11, e);
            repeat (2) recv(e, 400);
            repeat (40) @(negedge clock_i);
            `CHK(idle_o, 1'b1)
            stop_lvl = 1'b1;
            rx_i = 1'b1;
        end
    endtask
    task t_sec;
        rst;
        security_en_i = 1;
        sync(MATCH1_A, MATCH2_A);
        xfer(CMD_RAM, 9'h000);
        `CHK(idle_o, 1'b1)
        security_en_i = 0;
    endtask
    // Used part: count 5 at 0xC005, password compared from 0xC010
    task t_pw;
        logic [7:0] img [6];
        img = '{8'h00, 8'hC0, 8'h05, 8'h00, 8'hC0, 8'h10};
        rst;
        used = 1'b1;
        sync(MATCH1_B, MATCH2_B);
        xfer(CMD_RAM, {1'b1, CMD_RAM});
        foreach (img[i]) send(img[i]);
        send(8'h10);
        `CHK(idle_o, 1'b0)
        send(8'h66);
        repeat (8) @(negedge clock_i);
        `CHK(idle_o, 1'b1)
        used = 1'b0;
    endtask
    task wrap_up;
        if (fails == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        t_load;
        t_err;
        t_sec;
        t_pw;
        wrap_up;
    end
endmodule
